/* File: common/ssq_pkg.sv */
// Constants, mode type and decode helpers for the sample queue block
package ssq_pkg;

    localparam int unsigned SSQ_DEPTH = 32;
    localparam int unsigned SSQ_SAMPLE_W = 48;
    localparam int unsigned SSQ_DATA_BYTES = 6;

    localparam logic [7:0] SSQ_ADDR_DATA0 = 8'h32;
    localparam logic [7:0] SSQ_ADDR_CTRL = 8'h38;
    localparam logic [7:0] SSQ_ADDR_LEVEL = 8'h39;

    localparam logic [7:0] SSQ_CTRL_RESET = 8'h00;
    localparam int SSQ_MODE_MSB = 7;
    localparam int SSQ_MODE_LSB = 6;
    localparam int SSQ_ROUTE_BIT = 5;
    localparam int SSQ_SAMPLES_MSB = 4;

    localparam int SSQ_TRIG_BIT = 7;
    localparam int SSQ_ENTRY_W = 6;

    typedef enum logic [1:0] {
        SSQ_BYPASS,
        SSQ_FILL_STOP,
        SSQ_OVERWRITE,
        SSQ_TRIGGERED
    } ssq_mode_t;

    function automatic ssq_mode_t ssq_decode_mode(input logic [1:0] f);
        case (f)
            2'h0: ssq_decode_mode = SSQ_BYPASS;
            2'h1: ssq_decode_mode = SSQ_FILL_STOP;
            2'h2: ssq_decode_mode = SSQ_OVERWRITE;
            default: ssq_decode_mode = SSQ_TRIGGERED;
        endcase
    endfunction

    function automatic logic ssq_is_data_addr(input logic [7:0] a);
        ssq_is_data_addr = (a >= SSQ_ADDR_DATA0) &&
            (a < SSQ_ADDR_DATA0 + 8'(SSQ_DATA_BYTES));
    endfunction

endpackage

/* File: common/ssq_fifo_if.sv */
// Carrier between the queue controller and its storage FIFO
`timescale 1ns/1ps
interface ssq_fifo_if #(
    parameter int W = 48,
    parameter int D = 32
);
    localparam int CW = $clog2(D + 1);
    logic wr_valid;
    logic wr_ready;
    logic [W-1:0] wr_data;
    logic rd_req;
    logic rd_valid;
    logic [W-1:0] rd_data;
    logic [CW-1:0] count;
    logic flush;

    modport fifo (
        input wr_valid, wr_data, rd_req, flush,
        output wr_ready, rd_valid, rd_data, count
    );
    modport user (
        output wr_valid, wr_data, rd_req, flush,
        input wr_ready, rd_valid, rd_data, count
    );
endinterface

/* File: rtl/ssq_fifo.sv */
// Sample storage FIFO with registered read data
`timescale 1ns/1ps
module ssq_fifo #(
    parameter int W = 48,
    parameter int D = 32
) (
    input wire logic clk,
    input wire logic sys_rst,
    ssq_fifo_if.fifo q
);
    localparam int CW = $clog2(D + 1);
    localparam int AW = (D > 1) ? $clog2(D) : 1;

    logic [W-1:0] mem [D];
    logic [AW-1:0] wptr_reg;
    logic [AW-1:0] rptr_reg;
    logic [CW-1:0] count_reg;
    logic [W-1:0] rd_data_reg;
    logic rd_valid_reg;

    function automatic logic [AW-1:0] bump(input logic [AW-1:0] p);
        bump = (p == AW'(D - 1)) ? '0 : p + 1'b1;
    endfunction

    wire full = (count_reg == CW'(D));
    wire pop_ok = q.rd_req && (count_reg != '0);
    // Full FIFO still takes a word when a pop frees a slot this cycle
    wire push_ok = q.wr_valid && (!full || q.rd_req);
    wire [CW-1:0] inc = {{(CW-1){1'b0}}, push_ok};
    wire [CW-1:0] dec = {{(CW-1){1'b0}}, pop_ok};

    assign q.wr_ready = !full || q.rd_req;
    assign q.count = count_reg;
    assign q.rd_data = rd_data_reg;
    assign q.rd_valid = rd_valid_reg;

    always_ff @(posedge clk) begin
        if (push_ok) begin
            mem[wptr_reg] <= q.wr_data;
        end
        if (pop_ok) begin
            rd_data_reg <= mem[rptr_reg];
        end
    end

    always_ff @(posedge clk) begin
        if (sys_rst || q.flush) begin
            wptr_reg <= '0;
            rptr_reg <= '0;
            count_reg <= '0;
            rd_valid_reg <= 1'b0;
        end else begin
            wptr_reg <= push_ok ? bump(wptr_reg) : wptr_reg;
            rptr_reg <= pop_ok ? bump(rptr_reg) : rptr_reg;
            count_reg <= count_reg + inc - dec;
            rd_valid_reg <= pop_ok;
        end
    end
endmodule

/* File: rtl/ssq_sample_fifo_status.sv */
// Sample queue controller: modes, output stage and level register
//
// Contract
// - Fill/overwrite modes: count sets watermark level
// - Triggered mode: count is pre-trigger samples kept
// - Read-only level register, D6 reads zero
// - Trigger flag set once trigger event occurs in triggered mode
// - Entry field reports samples held in queue
// - Oldest sample shown through axis data registers
// - Any data register read burst pops one level at its end
// - 32 stored entries plus one output stage
// - Two-bit mode: bypass, fill, overwrite, triggered
// - Zero sample count sets watermark two cycles after the control write
`timescale 1ns/1ps
module ssq_sample_fifo_status #(
    parameter int DEPTH = ssq_pkg::SSQ_DEPTH,
    parameter int SAMPLE_W = ssq_pkg::SSQ_SAMPLE_W
) (
    input wire logic clk,
    input wire logic sys_rst,
    input wire logic samp_valid,
    input wire logic [SAMPLE_W-1:0] samp_data,
    output logic samp_ready,
    input wire logic trig_event,
    input wire logic [7:0] reg_addr,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_end,
    output logic [7:0] reg_rdata,
    output logic watermark,
    output logic trig_route
);
    localparam int CW = $clog2(DEPTH + 1);
    localparam int EW = ssq_pkg::SSQ_ENTRY_W;

    ssq_fifo_if #(.W(SAMPLE_W), .D(DEPTH)) q_if ();

    ssq_fifo #(.W(SAMPLE_W), .D(DEPTH)) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .q(q_if.user)
    );

    logic [7:0] ctrl_reg;
    logic [7:0] ctrl_next;
    logic trig_flag_reg;
    logic trig_flag_next;
    logic [SAMPLE_W-1:0] out_reg;
    logic [SAMPLE_W-1:0] out_next;
    logic out_valid_reg;
    logic out_valid_next;
    logic load_pend_reg;
    logic touched_reg;
    logic touched_next;
    logic [7:0] rdata_reg;
    logic [7:0] rdata_next;
    logic wm_reg;
    logic wm_next;
    logic ready_reg;
    logic ready_next;

    ssq_pkg::ssq_mode_t mode;
    assign mode = ssq_pkg::ssq_decode_mode(
        ctrl_reg[ssq_pkg::SSQ_MODE_MSB:ssq_pkg::SSQ_MODE_LSB]);

    wire [CW-1:0] samples = CW'(ctrl_reg[ssq_pkg::SSQ_SAMPLES_MSB:0]);
    wire [CW-1:0] cnt = q_if.count;
    wire full = (cnt == CW'(DEPTH));
    wire is_bypass = (mode == ssq_pkg::SSQ_BYPASS);
    wire ctl_wr = reg_wr && (reg_addr == ssq_pkg::SSQ_ADDR_CTRL);
    wire data_rd = reg_rd && ssq_pkg::ssq_is_data_addr(reg_addr);
    wire take = samp_valid && ready_reg;

    // Overwrite mode evicts oldest when full; triggered mode before the
    // trigger keeps only the programmed pre-trigger window
    wire stream_full = (mode == ssq_pkg::SSQ_OVERWRITE) && full;
    wire pre_trig = (mode == ssq_pkg::SSQ_TRIGGERED) && !trig_flag_reg;
    wire pre_over = pre_trig && (cnt != '0) && (cnt >= samples);
    wire push = take && !is_bypass && (!full || stream_full || pre_over);
    wire drop = push && (stream_full || pre_over);
    wire refill = !is_bypass && !out_valid_reg && !load_pend_reg &&
        (cnt != '0);
    wire pop = refill || drop;
    wire load_now = q_if.rd_valid && load_pend_reg;
    wire [CW-1:0] cnt_after = cnt + {{(CW-1){1'b0}}, push} -
        {{(CW-1){1'b0}}, pop};

    wire stop_mode = (mode == ssq_pkg::SSQ_FILL_STOP) ||
        ((mode == ssq_pkg::SSQ_TRIGGERED) && trig_flag_next);
    // A partial burst still pops; the host must read all bytes at once
    wire host_pop = reg_end && (touched_reg || data_rd);

    wire [EW-1:0] entries =
        is_bypass ? '0 : EW'(cnt);
    wire [7:0] level_byte = {trig_flag_reg, 1'b0, entries};
    wire [2:0] byte_idx = 3'(reg_addr - ssq_pkg::SSQ_ADDR_DATA0);
    wire [7:0] data_byte =
        out_valid_reg ? out_reg[8*byte_idx +: 8] : 8'h00;
    wire [7:0] rd_mux =
        ssq_pkg::ssq_is_data_addr(reg_addr) ? data_byte :
        (reg_addr == ssq_pkg::SSQ_ADDR_CTRL) ? ctrl_reg :
        (reg_addr == ssq_pkg::SSQ_ADDR_LEVEL) ? level_byte : 8'h00;

    assign q_if.wr_valid = push;
    assign q_if.wr_data = samp_data;
    assign q_if.rd_req = pop;
    // Returning to bypass discards whatever was queued
    assign q_if.flush = ctl_wr && (ssq_pkg::ssq_decode_mode(
        reg_wdata[ssq_pkg::SSQ_MODE_MSB:ssq_pkg::SSQ_MODE_LSB]) ==
        ssq_pkg::SSQ_BYPASS);

    always_comb begin
        ctrl_next = ctl_wr ? reg_wdata : ctrl_reg;
        // Trigger beats a same-cycle control write
        trig_flag_next = trig_flag_reg && !ctl_wr;
        if ((mode == ssq_pkg::SSQ_TRIGGERED) && trig_event) begin
            trig_flag_next = 1'b1;
        end
        out_next = out_reg;
        out_valid_next = out_valid_reg;
        if (is_bypass && take) begin
            out_next = samp_data;
            out_valid_next = 1'b1;
        end else if (load_now) begin
            out_next = q_if.rd_data;
            out_valid_next = 1'b1;
        end else if (host_pop) begin
            out_valid_next = 1'b0;
        end
        touched_next = !reg_end && (touched_reg || data_rd);
        rdata_next = reg_rd ? rd_mux : rdata_reg;
        wm_next = (samples == '0) ||
            (!is_bypass && (mode != ssq_pkg::SSQ_TRIGGERED) &&
            (cnt_after >= samples));
        ready_next = !(stop_mode && (cnt_after == CW'(DEPTH)));
    end

    always_ff @(posedge clk) begin
        if (sys_rst) begin
            ctrl_reg <= ssq_pkg::SSQ_CTRL_RESET;
            trig_flag_reg <= 1'b0;
            out_valid_reg <= 1'b0;
            load_pend_reg <= 1'b0;
            touched_reg <= 1'b0;
            rdata_reg <= 8'h00;
            wm_reg <= 1'b0;
            ready_reg <= 1'b0;
            out_reg <= '0;
        end else begin
            ctrl_reg <= ctrl_next;
            trig_flag_reg <= trig_flag_next;
            out_valid_reg <= out_valid_next;
            load_pend_reg <= refill && !q_if.flush;
            touched_reg <= touched_next;
            rdata_reg <= rdata_next;
            wm_reg <= wm_next;
            ready_reg <= ready_next;
            out_reg <= out_next;
        end
    end

    assign samp_ready = ready_reg;
    assign reg_rdata = rdata_reg;
    assign watermark = wm_reg;
    assign trig_route = ctrl_reg[ssq_pkg::SSQ_ROUTE_BIT];

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    AST_LEVEL_D6_ZERO: assert property (
        reg_rd && (reg_addr == ssq_pkg::SSQ_ADDR_LEVEL) |=> !reg_rdata[6])
        else $error("level register bit 6 not zero");
    AST_ENTRIES_MATCH: assert property (
        reg_rd && (reg_addr == ssq_pkg::SSQ_ADDR_LEVEL) && !is_bypass
        |=> reg_rdata[5:0] == $past(EW'(cnt)))
        else $error("entry field differs from queue count");
    AST_BYPASS_ZERO: assert property (
        reg_rd && (reg_addr == ssq_pkg::SSQ_ADDR_LEVEL) && is_bypass
        |=> reg_rdata[5:0] == 6'h00)
        else $error("bypass entry field not zero");
    AST_TRIG_SET: assert property (
        (mode == ssq_pkg::SSQ_TRIGGERED) && trig_event
        |=> trig_flag_reg ##1 (trig_flag_reg || $past(ctl_wr)))
        else $error("trigger flag not set after trigger");
    AST_TRIG_HOLD: assert property (
        trig_flag_reg && !ctl_wr |=> trig_flag_reg)
        else $error("trigger flag lost without control write");
    AST_ZERO_WM: assert property (
        ctl_wr && (reg_wdata[4:0] == 5'h00) |=> ##1 watermark)
        else $error("zero sample count did not raise watermark");
    AST_WM_LEVEL: assert property (
        !is_bypass && (mode != ssq_pkg::SSQ_TRIGGERED) && !ctl_wr &&
        $stable(ctrl_reg) && (cnt >= samples) |-> watermark)
        else $error("watermark low at or above level");
    AST_CAPACITY: assert property (
        (cnt <= CW'(DEPTH)) && (!push || q_if.wr_ready))
        else $error("queue exceeds capacity");
    AST_FILL_STOP: assert property (
        (mode == ssq_pkg::SSQ_FILL_STOP) && full |-> !push)
        else $error("fill mode accepted sample while full");
    AST_PRETRIG_WINDOW: assert property (
        push && pre_over |-> pop ##1 (cnt <= $past(cnt)))
        else $error("pre-trigger window grew");
    AST_POP_ON_READ: assert property (
        host_pop && out_valid_reg && !load_now && !(is_bypass && take)
        |=> !out_valid_reg)
        else $error("data read did not pop output stage");
    AST_DATA_SHOWN: assert property (
        reg_rd && (reg_addr == ssq_pkg::SSQ_ADDR_DATA0) && out_valid_reg
        |=> reg_rdata == $past(out_reg[7:0]))
        else $error("data register not showing oldest sample");

    COV_FILL_FULL: cover property (
        (mode == ssq_pkg::SSQ_FILL_STOP) && full);
    COV_OVERWRITE: cover property (drop && stream_full);
    COV_TRIGGERED: cover property (
        pre_trig && trig_event ##[1:40] full);
    COV_BURST_POP: cover property (data_rd ##1 data_rd ##1 host_pop);
endmodule

/* File: verification/ssq_host.sv */
// Host model driving the register strobes of the sample queue
`timescale 1ns/1ps
module ssq_host (
    input wire logic clk,
    input wire logic [7:0] reg_rdata,
    output logic [7:0] reg_addr,
    output logic reg_wr,
    output logic reg_rd,
    output logic [7:0] reg_wdata,
    output logic reg_end
);
    initial begin
        reg_addr = 8'h00;
        reg_wr = 1'b0;
        reg_rd = 1'b0;
        reg_wdata = 8'h00;
        reg_end = 1'b0;
    end

    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        reg_addr = a;
        reg_wdata = d;
        reg_wr = 1'b1;
        reg_end = 1'b1;
        @(negedge clk);
        reg_wr = 1'b0;
        reg_end = 1'b0;
        // Released bus must not keep the last byte
        reg_wdata = ~d;
    endtask

    // Whole sample in one burst, a lone byte read pops the entry
    task automatic rd(input logic [7:0] a, input int n,
        output logic [47:0] v);
        v = 48'h0;
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            if (i > 0) v[8*(i-1) +: 8] = reg_rdata;
            reg_addr = a + 8'(i);
            reg_rd = 1'b1;
            reg_end = (i == n - 1);
        end
        @(negedge clk);
        v[8*(n-1) +: 8] = reg_rdata;
        reg_rd = 1'b0;
        reg_end = 1'b0;
        reg_addr = ~reg_addr;
    endtask
endmodule

/* File: verification/tb.sv */
// Self-checking bench of the sample queue controller
`timescale 1ns/1ps
module tb;
    logic clk, sys_rst, samp_valid, samp_ready, trig_event, watermark;
    logic reg_wr, reg_rd, reg_end, trig_route;
    logic [7:0] reg_addr, reg_wdata, reg_rdata;
    logic [47:0] samp_data, v;
    logic [47:0] q[$];
    logic [31:0] seed;
    int fail_count, n_tests, acc;

    ssq_sample_fifo_status dut (.clk(clk), .sys_rst(sys_rst),
        .samp_valid(samp_valid), .samp_data(samp_data),
        .samp_ready(samp_ready), .trig_event(trig_event),
        .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_wdata(reg_wdata), .reg_end(reg_end), .reg_rdata(reg_rdata),
        .watermark(watermark), .trig_route(trig_route));
    ssq_host host (.clk(clk), .reg_rdata(reg_rdata), .reg_addr(reg_addr),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_wdata(reg_wdata),
        .reg_end(reg_end));

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    task automatic check(input logic [47:0] seen, input logic [47:0] exp);
        n_tests++;
        if (seen !== exp) begin
            fail_count++;
            $display("wrong value at %0t: saw %h want %h", $time, seen, exp);
        end
    endtask

    task automatic wrap_up;
        $display("comparisons %0d mismatches %0d", n_tests, fail_count);
        if (fail_count == 0 && n_tests > 0) $display("All checks passed");
        else $display("Checks failed");
        $finish;
    endtask

    // Offer only when ready is seen, so the model knows what was taken
    task automatic push(input int n);
        for (int i = 0; i < n; i++) begin
            @(negedge clk);
            seed = lfsr(lfsr(seed));
            samp_data = {seed[31:16], seed};
            samp_valid = samp_ready;
            if (samp_ready === 1'b1) begin
                q.push_back(samp_data);
                acc++;
            end
        end
        @(negedge clk);
        samp_valid = 1'b0;
        repeat (8) @(negedge clk);
    endtask

    task automatic level(input logic [7:0] exp);
        host.rd(ssq_pkg::SSQ_ADDR_LEVEL, 1, v);
        check(v, {40'h0, exp});
    endtask

    function automatic logic [7:0] ent();
        return {2'h0, 6'(q.size() > 0 ? q.size() - 1 : 0)};
    endfunction

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Tests need under 2000 cycles
    initial begin
        #500000;
        fail_count++;
        wrap_up();
    end

    initial begin
        sys_rst = 1'b1;
        samp_valid = 1'b0;
        samp_data = 48'h0;
        trig_event = 1'b0;
        seed = 32'h9AA224CE;
        fail_count = 0;
        n_tests = 0;
        acc = 0;
        repeat (20) @(negedge clk);
        sys_rst = 1'b0;
        repeat (2) @(negedge clk);
        check({40'h0, reg_rdata}, 48'h0);
        level(8'h00);
        check({47'h0, watermark}, 48'h1);
        $display("test reset done");
        host.wr(ssq_pkg::SSQ_ADDR_CTRL, 8'h44);
        push(4);
        level(ent());
        check({47'h0, watermark}, 48'h0);
        push(1);
        check({47'h0, watermark}, 48'h1);
        push(40);
        check(48'(q.size()), 48'h21);
        level(ent());
        repeat (4) begin
            host.rd(ssq_pkg::SSQ_ADDR_DATA0, 6, v);
            check(v, q.pop_front());
            repeat (6) @(negedge clk);
            level(ent());
        end
        host.rd(ssq_pkg::SSQ_ADDR_DATA0, 1, v);
        check(v, {40'h0, q[0][7:0]});
        q.delete(0);
        repeat (6) @(negedge clk);
        level(ent());
        host.wr(ssq_pkg::SSQ_ADDR_LEVEL, 8'hFF);
        level(ent());
        $display("test fill done");
        host.wr(ssq_pkg::SSQ_ADDR_CTRL, 8'h00);
        push(3);
        level(8'h00);
        host.rd(ssq_pkg::SSQ_ADDR_DATA0, 6, v);
        check(v, q[$]);
        q.delete();
        $display("test bypass done");
        host.wr(ssq_pkg::SSQ_ADDR_CTRL, 8'hE4);
        check({47'h0, trig_route}, 48'h1);
        host.rd(ssq_pkg::SSQ_ADDR_CTRL, 1, v);
        check(v, {40'h0, 8'hE4});
        push(10);
        level(8'h04);
        @(negedge clk);
        trig_event = 1'b1;
        @(negedge clk);
        trig_event = 1'b0;
        level(8'h84);
        push(45);
        level(8'hA0);
        check({47'h0, watermark}, 48'h0);
        host.wr(ssq_pkg::SSQ_ADDR_CTRL, 8'hE0);
        repeat (2) @(negedge clk);
        check({47'h0, watermark}, 48'h1);
        $display("test trigger done");
        host.wr(ssq_pkg::SSQ_ADDR_CTRL, 8'h00);
        host.wr(ssq_pkg::SSQ_ADDR_CTRL, 8'h82);
        check({47'h0, trig_route}, 48'h0);
        acc = 0;
        push(45);
        check(48'(acc), 48'h2D);
        level(8'h20);
        check({47'h0, watermark}, 48'h1);
        $display("test overwrite done");
        wrap_up();
    end
endmodule
